// ### common/adcc_pkg.sv
// Purpose: Shared constants, codes and decode functions for the converter control block
// Assumes: 8-bit register port, 10-bit conversion result
// Notes: Register offsets are indices on the plain register port
package adcc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam int IRQ_W = 2;

    // Register offsets
    localparam logic [3:0] OFF_CTRL0 = 4'h0;
    localparam logic [3:0] OFF_CTRL1 = 4'h1;
    localparam logic [3:0] OFF_RES_HI = 4'h2;
    localparam logic [3:0] OFF_RES_LO = 4'h3;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFF_IRQ_CLR = 4'h5;
    localparam logic [3:0] OFF_IRQ_EN = 4'h6;

    // converter_control_0 fields
    localparam int CTL0_EN_BIT = 0;
    localparam int CTL0_GO_BIT = 1;
    localparam int CTL0_CHAN_LSB = 2;
    // converter_control_1 fields
    localparam int CTL1_PREF_LSB = 0;
    localparam int CTL1_NREF_BIT = 2;
    localparam int CTL1_CLK_LSB = 4;
    localparam int CTL1_JUST_BIT = 7;

    // Reset values
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 2'h0;

    // Interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;

    // Channel codes
    localparam logic [4:0] CHAN_LAST_STD = 5'h08;
    localparam logic [4:0] CHAN_LAST_WIDE = 5'h0B;
    localparam logic [4:0] CHAN_FIRST_RSVD = 5'h0C;
    localparam logic [4:0] CHAN_LAST_RSVD = 5'h1D;
    localparam logic [4:0] CHAN_DAC = 5'h1E;
    localparam logic [4:0] CHAN_FIXED_REF = 5'h1F;

    localparam logic [9:0] SAR_MSB_TRIAL = 10'h200;
    localparam logic [3:0] SAR_MSB_IDX = 4'h9;

    typedef enum logic [2:0] {
        CLK_DIV2 = 3'b000,
        CLK_DIV8 = 3'b001,
        CLK_DIV32 = 3'b010,
        CLK_RC = 3'b011,
        CLK_DIV4 = 3'b100,
        CLK_DIV16 = 3'b101,
        CLK_DIV64 = 3'b110,
        CLK_RC_ALT = 3'b111
    } adcc_clk_sel_t;

    function automatic logic is_rc(input logic [2:0] sel);
        return (sel == CLK_RC) || (sel == CLK_RC_ALT);
    endfunction

    // Low counter bits that must all be one for a divided tick
    function automatic logic [5:0] div_mask(input logic [2:0] sel);
        case (sel)
            CLK_DIV2: return 6'h01;
            CLK_DIV4: return 6'h03;
            CLK_DIV8: return 6'h07;
            CLK_DIV16: return 6'h0F;
            CLK_DIV32: return 6'h1F;
            CLK_DIV64: return 6'h3F;
            default: return 6'h00;
        endcase
    endfunction
endpackage

// ### common/adcc_conv_if.sv
// Purpose: Link between register front end and successive-approximation engine
// Assumes: Single clock, all signals synchronous
// Notes: start, stop, kill and tick are one-cycle pulses
interface adcc_conv_if;
    logic start;
    logic stop;
    logic kill;
    logic tick;
    logic cmp_high;
    logic busy;
    logic done;
    logic res_valid;
    logic [9:0] result;
    logic [9:0] trial;

    modport eng (
        input start, stop, kill, tick, cmp_high,
        output busy, done, res_valid, result, trial
    );
    modport ctl (
        output start, stop, kill, tick, cmp_high,
        input busy, done, res_valid, result, trial
    );
endinterface

// ### hw/adcc_sar.sv
// Purpose: Successive-approximation sequencer, one bit per conversion tick
// Assumes: Comparator input is valid at each tick for the trial word driven out
// Notes: Stop stores a partial word, kill drops the conversion silently
module adcc_sar (
    input wire logic clock,
    input wire logic rst_n,
    adcc_conv_if.eng cv
);
    import adcc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV = 2'b10
    } adcc_sar_st_t;

    typedef struct packed {
        adcc_sar_st_t st;
        logic [3:0] idx;
        logic [9:0] sar;
        logic [9:0] result;
        logic done;
        logic res_valid;
    } adcc_sar_state_t;

    adcc_sar_state_t q, d;

    // Unconverted bits copy the last converted bit
    function automatic logic [9:0] partial(input logic [9:0] s, input logic [3:0] idx);
        logic [9:0] r;
        logic last;
        r = 10'h000;
        last = (idx == SAR_MSB_IDX) ? 1'b0 : s[4'(idx + 4'h1)];
        for (int i = 0; i < RES_W; i++) begin
            r[i] = (4'(i) > idx) ? s[i] : last;
        end
        return r;
    endfunction

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.res_valid = 1'b0;
        unique case (q.st)
            ST_IDLE: begin
                if (cv.start) begin
                    d.st = ST_SAMPLE;
                    d.sar = 10'h000;
                end
            end
            ST_SAMPLE: begin
                if (cv.kill) begin
                    d.st = ST_IDLE;
                end else if (cv.stop) begin
                    d.result = 10'h000;
                    d.res_valid = 1'b1;
                    d.st = ST_IDLE;
                end else if (cv.tick) begin
                    d.st = ST_CONV;
                    d.idx = SAR_MSB_IDX;
                    d.sar = SAR_MSB_TRIAL;
                end
            end
            ST_CONV: begin
                if (cv.kill) begin
                    d.st = ST_IDLE;
                end else if (cv.stop) begin
                    d.result = partial(q.sar, q.idx);
                    d.res_valid = 1'b1;
                    d.st = ST_IDLE;
                end else if (cv.tick) begin
                    d.sar[q.idx] = cv.cmp_high;
                    if (q.idx == 4'h0) begin
                        d.result = d.sar;
                        d.done = 1'b1;
                        d.res_valid = 1'b1;
                        d.st = ST_IDLE;
                    end else begin
                        d.sar[4'(q.idx - 4'h1)] = 1'b1;
                        d.idx = 4'(q.idx - 4'h1);
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cv.busy = (q.st != ST_IDLE);
    assign cv.done = q.done;
    assign cv.res_valid = q.res_valid;
    assign cv.result = q.result;
    assign cv.trial = q.sar;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_stop_partial;
        cv.stop && !cv.kill && (q.st == ST_CONV) |=> cv.res_valid && !cv.busy && !cv.done;
    endproperty
    a_stop_partial: assert property (p_stop_partial) else $error("stop gave no partial result");

    property p_kill_quiet;
        cv.kill && cv.busy |=> !cv.res_valid && !cv.busy;
    endproperty
    a_kill_quiet: assert property (p_kill_quiet) else $error("kill did not end quietly");

    c_full: cover property (cv.done);
    c_partial: cover property (cv.stop && q.st == ST_CONV);
endmodule // adcc_sar

// ### hw/adcc_top.sv
// Purpose: Register front end, clock selection and control for a 10-bit converter
// Assumes: Register port strobes are one cycle; comparator and rc tick are synchronous
// Notes: Read data stand only in the cycle after the read strobe
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
module adcc_top #(
    parameter bit WIDE_PKG = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [adcc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [adcc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [adcc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic cpu_sleep,
    input wire logic rc_osc_tick,
    input wire logic comparator_high,
    output logic converter_power,
    output logic [adcc_pkg::RES_W-1:0] dac_trial,
    output logic input_connect,
    output logic [3:0] input_index,
    output logic route_dac,
    output logic route_fixed_ref,
    output logic neg_ref_sel,
    output logic [1:0] pos_ref_sel,
    output logic irq
);
    import adcc_pkg::*;

    typedef struct packed {
        logic [4:0] chan;
        logic go;
        logic en;
        logic just;
        logic [2:0] clk_sel;
        logic nref;
        logic [1:0] pref;
        logic [RES_W-1:0] result;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [DATA_W-1:0] rdata;
        logic [5:0] div_cnt;
        logic tick;
        logic start;
        logic stop;
        logic kill;
        logic sleep_off;
        logic in_conn;
        logic [3:0] in_idx;
        logic dac;
        logic fixed_ref;
    } adcc_top_state_t;

    adcc_top_state_t q, d;
    adcc_conv_if cv ();

    logic [7:0] res_hi_view;
    logic [7:0] res_lo_view;
    logic [5:0] mask;

    always_comb begin
        res_hi_view = q.just ? {6'h00, q.result[9:8]} : q.result[9:2];
        res_lo_view = q.just ? q.result[7:0] : {q.result[1:0], 6'h00};
    end

    always_comb begin
        d = q;
        d.start = 1'b0;
        d.stop = 1'b0;
        d.kill = 1'b0;
        mask = div_mask(q.clk_sel);

        // Conversion clock enable
        d.div_cnt = 6'(q.div_cnt + 6'h01);
        if (is_rc(q.clk_sel)) begin
            d.tick = rc_osc_tick;
        end else begin
            d.tick = ((q.div_cnt & mask) == mask);
        end

        // Read port, data valid one cycle only
        d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFF_CTRL0: d.rdata = {1'b0, q.chan, q.go, q.en};
                OFF_CTRL1: d.rdata = {q.just, q.clk_sel, 1'b0, q.nref, q.pref};
                OFF_RES_HI: d.rdata = res_hi_view;
                OFF_RES_LO: d.rdata = res_lo_view;
                OFF_IRQ_STAT: d.rdata = {6'h00, q.irq_stat};
                OFF_IRQ_EN: d.rdata = {6'h00, q.irq_en};
                default: d.rdata = 8'h00;
            endcase
        end

        if (reg_wr) begin
            case (reg_addr)
                OFF_CTRL0: begin
                    d.chan = reg_wdata[CTL0_CHAN_LSB +: 5];
                    d.en = reg_wdata[CTL0_EN_BIT];
                    if (!reg_wdata[CTL0_EN_BIT]) begin
                        if (q.go) begin
                            d.go = 1'b0;
                            d.kill = 1'b1;
                        end
                    end else if (reg_wdata[CTL0_GO_BIT] && !q.go) begin
                        d.go = 1'b1;
                        d.start = 1'b1;
                    end else if (!reg_wdata[CTL0_GO_BIT] && q.go) begin
                        d.go = 1'b0;
                        d.stop = 1'b1;
                    end
                end
                OFF_CTRL1: begin
                    d.just = reg_wdata[CTL1_JUST_BIT];
                    d.clk_sel = reg_wdata[CTL1_CLK_LSB +: 3];
                    d.nref = reg_wdata[CTL1_NREF_BIT];
                    d.pref = reg_wdata[CTL1_PREF_LSB +: 2];
                end
                OFF_IRQ_CLR: d.irq_stat = q.irq_stat & ~reg_wdata[IRQ_W-1:0];
                OFF_IRQ_EN: d.irq_en = reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // Engine events; set wins over a clear in the same cycle
        if (cv.done) begin
            d.go = 1'b0;
            d.irq_stat[IRQ_DONE_BIT] = 1'b1;
        end
        if (cv.res_valid) begin
            d.result = cv.result;
        end
        if ((q.stop || q.kill) && cv.busy) begin
            d.irq_stat[IRQ_ABORT_BIT] = 1'b1;
        end

        // Sleep abort, enable bit left as is
        if (cpu_sleep && !is_rc(q.clk_sel)) begin
            d.sleep_off = 1'b1;
            if (q.go || d.go) begin
                d.go = 1'b0;
                d.start = 1'b0;
                d.stop = 1'b0;
                d.kill = 1'b1;
            end
        end else if (!cpu_sleep) begin
            d.sleep_off = 1'b0;
        end

        // Analog input routing
        d.in_conn = (q.chan <= CHAN_LAST_STD)
            || (WIDE_PKG && (q.chan <= CHAN_LAST_WIDE));
        d.in_idx = d.in_conn ? q.chan[3:0] : 4'h0;
        d.dac = (q.chan == CHAN_DAC);
        d.fixed_ref = (q.chan == CHAN_FIXED_REF);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.chan <= CTRL0_RST[CTL0_CHAN_LSB +: 5];
            q.go <= CTRL0_RST[CTL0_GO_BIT];
            q.en <= CTRL0_RST[CTL0_EN_BIT];
            q.just <= CTRL1_RST[CTL1_JUST_BIT];
            q.clk_sel <= CTRL1_RST[CTL1_CLK_LSB +: 3];
            q.nref <= CTRL1_RST[CTL1_NREF_BIT];
            q.pref <= CTRL1_RST[CTL1_PREF_LSB +: 2];
            q.irq_en <= IRQ_EN_RST;
        end else begin
            q <= d;
        end
    end

    assign cv.start = q.start;
    assign cv.stop = q.stop;
    assign cv.kill = q.kill;
    assign cv.tick = q.tick;
    assign cv.cmp_high = comparator_high;

    adcc_sar u_sar (
        .clock(clock),
        .rst_n(rst_n),
        .cv(cv.eng)
    );

    assign reg_rdata = q.rdata;
    assign converter_power = q.en && !q.sleep_off;
    assign dac_trial = cv.trial;
    assign input_connect = q.in_conn;
    assign input_index = q.in_idx;
    assign route_dac = q.dac;
    assign route_fixed_ref = q.fixed_ref;
    assign neg_ref_sel = q.nref;
    assign pos_ref_sel = q.pref;
    assign irq = |(q.irq_stat & q.irq_en);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic wr_ctrl0;
    assign wr_ctrl0 = reg_wr && (reg_addr == OFF_CTRL0);

    property p_start;
        wr_ctrl0 && reg_wdata[CTL0_GO_BIT] && reg_wdata[CTL0_EN_BIT] && !q.go && !cpu_sleep
            |=> q.go ##1 cv.busy;
    endproperty
    a_start: assert property (p_start) else $error("go write did not start");

    property p_go_read;
        reg_rd && (reg_addr == OFF_CTRL0) && q.go |=> reg_rdata[CTL0_GO_BIT];
    endproperty
    a_go_read: assert property (p_go_read) else $error("busy status read as zero");

    property p_done_clears;
        cv.done |=> !q.go && q.irq_stat[IRQ_DONE_BIT];
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("status not cleared on done");

    property p_idle;
        !q.go && !q.stop && !q.kill |-> !cv.busy;
    endproperty
    a_idle: assert property (p_idle) else $error("engine busy with status zero");

    property p_power_off;
        wr_ctrl0 && !reg_wdata[CTL0_EN_BIT] |=> !converter_power ##1 !cv.busy;
    endproperty
    a_power_off: assert property (p_power_off) else $error("converter still powered");

    property p_left;
        reg_rd && (reg_addr == OFF_RES_HI) && !q.just |=> reg_rdata == $past(q.result[9:2]);
    endproperty
    a_left: assert property (p_left) else $error("left justified high result wrong");

    property p_right;
        reg_rd && (reg_addr == OFF_RES_LO) && q.just |=> reg_rdata == $past(q.result[7:0]);
    endproperty
    a_right: assert property (p_right) else $error("right justified low result wrong");

    property p_sleep;
        cpu_sleep && !is_rc(q.clk_sel) && q.en |=> !converter_power && !q.go && q.en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not abort conversion");

    property p_reserved;
        (q.chan >= CHAN_FIRST_RSVD) && (q.chan <= CHAN_LAST_RSVD)
            |=> !input_connect && !route_dac;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved channel connected");

    property p_dac_route;
        q.chan == CHAN_DAC |=> route_dac && !route_fixed_ref && !input_connect;
    endproperty
    a_dac_route: assert property (p_dac_route) else $error("dac channel not routed");

    c_conv_done: cover property (q.go ##[1:800] cv.done);
    c_sleep_abort: cover property (cpu_sleep && q.go && !is_rc(q.clk_sel));
    c_irq: cover property (irq);
endmodule // adcc_top

// ### verification/adcc_tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Comparator modelled as input level at or above the trial word
// Notes: Random values from a seeded xorshift, corner cases written by hand
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module adcc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adcc_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic cpu_sleep = 1'b0;
    logic rc_osc_tick = 1'b0;
    logic comparator_high;
    logic converter_power;
    logic [9:0] dac_trial;
    logic input_connect;
    logic [3:0] input_index;
    logic route_dac;
    logic route_fixed_ref;
    logic neg_ref_sel;
    logic [1:0] pos_ref_sel;
    logic irq;
    logic [9:0] vin = 10'h000;
    logic [1:0] rc_cnt = 2'h0;
    logic [7:0] rdv;
    logic [31:0] seed = 32'h301B7A70;
    logic [31:0] r;
    int err_total = 0;
    int checks_done = 0;

    adcc_top #(.WIDE_PKG(1'b1)) adcc_top_i (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_sleep(cpu_sleep),
        .rc_osc_tick(rc_osc_tick), .comparator_high(comparator_high),
        .converter_power(converter_power), .dac_trial(dac_trial),
        .input_connect(input_connect), .input_index(input_index), .route_dac(route_dac),
        .route_fixed_ref(route_fixed_ref),
        .neg_ref_sel(neg_ref_sel), .pos_ref_sel(pos_ref_sel),
        .irq(irq)
    );

    // Analog side: input level compared with the trial word
    assign comparator_high = (vin >= dac_trial);

    initial begin
        forever #50 clock = ~clock;
    end

    // Dedicated oscillator pulse every fourth cycle
    always @(posedge clock) begin
        rc_cnt <= rc_cnt + 2'h1;
        rc_osc_tick <= &rc_cnt;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] exp_hi(input logic [9:0] v, input logic j);
        return j ? {6'h00, v[9:8]} : v[9:2];
    endfunction

    function automatic logic [7:0] exp_lo(input logic [9:0] v, input logic j);
        return j ? v[7:0] : {v[1:0], 6'h00};
    endfunction

    task automatic report_and_stop();
        $display("err_total %0d checks_done %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        rd(OFF_CTRL0);
        while (rdv[CTL0_GO_BIT] !== 1'b0 && n < 1000) begin
            rd(OFF_CTRL0);
            n++;
        end
        if (n >= 1000) begin
            err_total++;
            $display("CHECK FAILED go bit clear exp 0 got %0h", rdv[CTL0_GO_BIT]);
            report_and_stop();
        end
    endtask

    task automatic conv(input logic [2:0] cs, input logic j, input logic [9:0] v,
                        input logic [4:0] ch);
        logic [7:0] m;
        m = j ? 8'h03 : 8'hC0;
        wr(OFF_CTRL1, {j, cs, 4'h0});
        vin <= v;
        wr(OFF_CTRL0, {1'b0, ch, 2'b11});
        rd(OFF_CTRL0);
        `CHK("go while running", 1'b1, rdv[CTL0_GO_BIT])
        `CHK("power while running", 1'b1, converter_power)
        wait_idle();
        `CHK("enable after done", 1'b1, rdv[CTL0_EN_BIT])
        rd(OFF_RES_HI);
        `CHK("result high", exp_hi(v, j) & (j ? 8'h03 : 8'hFF), rdv & (j ? 8'h03 : 8'hFF))
        rd(OFF_RES_LO);
        `CHK("result low", exp_lo(v, j) & (j ? 8'hFF : m), rdv & (j ? 8'hFF : m))
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(a[3:0]);
            `CHK("reset read", 8'h00, rdv)
        end
        `CHK("power at reset", 1'b0, converter_power)
        wr(4'h7, 8'hFF);
        rd(4'h7);
        `CHK("unmapped read", 8'h00, rdv)
        wr(OFF_RES_HI, 8'hFF);
        rd(OFF_RES_HI);
        `CHK("result read only", 8'h00, rdv)
        wr(OFF_IRQ_EN, 8'h03);
        for (int c = 0; c < 32; c++) begin
            wr(OFF_CTRL0, {1'b0, c[4:0], 2'b00});
            rd(OFF_CTRL0);
            `CHK("channel readback", {1'b0, c[4:0], 2'b00}, rdv)
            `CHK("pin routed", (c <= 11), input_connect)
            `CHK("pin index", (c <= 11) ? c[3:0] : 4'h0, input_index)
            `CHK("dac routed", (c == 30), route_dac)
            `CHK("fixed ref routed", (c == 31), route_fixed_ref)
        end
        wr(OFF_CTRL0, 8'h02);
        rd(OFF_CTRL0);
        `CHK("go without enable", 8'h00, rdv)
        `CHK("power without enable", 1'b0, converter_power)
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            wr(OFF_CTRL1, r[7:0]);
            rd(OFF_CTRL1);
            `CHK("control 1 readback", r[7:0] & 8'hF7, rdv)
            `CHK("negative ref", r[2], neg_ref_sel)
            `CHK("positive ref", r[1:0], pos_ref_sel)
        end
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            conv(k[2:0], r[10], r[9:0], {1'b0, r[15:12] % 4'hC});
        end
        rd(OFF_IRQ_STAT);
        `CHK("done flag", 1'b1, rdv[IRQ_DONE_BIT])
        `CHK("irq on done", 1'b1, irq)
        wr(OFF_IRQ_CLR, 8'h01);
        @(posedge clock);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        conv(3'b000, 1'b0, 10'h3FF, 5'h00);
        conv(3'b000, 1'b1, 10'h000, 5'h0B);
        // Software stop with all-ones input
        wr(OFF_CTRL1, 8'h00);
        vin <= 10'h3FF;
        wr(OFF_CTRL0, 8'h03);
        repeat (10) @(posedge clock);
        wr(OFF_CTRL0, 8'h01);
        rd(OFF_CTRL0);
        `CHK("go after stop", 8'h01, rdv)
        repeat (3) @(posedge clock);
        rd(OFF_RES_HI);
        `CHK("partial high", 8'hFF, rdv)
        rd(OFF_RES_LO);
        `CHK("partial low", 8'hC0, rdv & 8'hC0)
        rd(OFF_IRQ_STAT);
        `CHK("abort flag", 1'b1, rdv[IRQ_ABORT_BIT])
        // Enable cleared mid-conversion
        wr(OFF_CTRL0, 8'h03);
        repeat (6) @(posedge clock);
        wr(OFF_CTRL0, 8'h00);
        rd(OFF_CTRL0);
        `CHK("go after disable", 8'h00, rdv)
        `CHK("power after disable", 1'b0, converter_power)
        // Sleep with a divided clock aborts
        wr(OFF_CTRL1, 8'h60);
        wr(OFF_CTRL0, 8'h03);
        repeat (20) @(posedge clock);
        cpu_sleep <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        `CHK("power in sleep", 1'b0, converter_power)
        rd(OFF_CTRL0);
        `CHK("enable kept in sleep", 8'h01, rdv)
        cpu_sleep <= 1'b0;
        wr(OFF_IRQ_EN, 8'h00);
        @(posedge clock);
        #1;
        `CHK("irq masked", 1'b0, irq)
        wr(OFF_IRQ_EN, 8'h02);
        @(posedge clock);
        #1;
        `CHK("irq abort enabled", 1'b1, irq)
        wr(OFF_IRQ_CLR, 8'h03);
        rd(OFF_IRQ_STAT);
        `CHK("status cleared", 8'h00, rdv)
        `CHK("irq after clear", 1'b0, irq)
        // Sleep with the oscillator clock keeps converting
        wr(OFF_CTRL0, 8'h00);
        wr(OFF_CTRL1, 8'h30);
        cpu_sleep <= 1'b1;
        r = rnd();
        conv(3'b011, 1'b1, r[9:0], 5'h03);
        cpu_sleep <= 1'b0;
        // Reset in mid-conversion returns everything to off
        wr(OFF_CTRL0, 8'h03);
        repeat (4) @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFF_CTRL0);
        `CHK("control 0 after reset", 8'h00, rdv)
        `CHK("power after reset", 1'b0, converter_power)
        `CHK("irq after reset", 1'b0, irq)
        report_and_stop();
    end
endmodule // adcc_tb_top
